// ==== hdl/iosd_pkg.sv ====
// package: i/o space decoder offsets, masks, request and reply types
package iosd_pkg;

   // ****************************************
   // address space bounds
   // ****************************************
   localparam int unsigned IO_SPAN      = 64;      // short i/o locations
   localparam logic [2:0]  BIT_SPAN_TOP = 3'h0;    // addr[7:5] of bit space
   localparam logic [7:0]  DS_IO_BASE   = 8'h20;   // data-space i/o offset
   localparam logic [7:0]  DS_EXT_BASE  = 8'h60;   // extended i/o start

   // ****************************************
   // register offsets (i/o addresses)
   // ****************************************
   localparam logic [5:0] OFF_PB_PIN   = 6'h03;
   localparam logic [5:0] OFF_PB_DIR   = 6'h04;
   localparam logic [5:0] OFF_PB_OUT   = 6'h05;
   localparam logic [5:0] OFF_PC_PIN   = 6'h06;
   localparam logic [5:0] OFF_PC_DIR   = 6'h07;
   localparam logic [5:0] OFF_PC_OUT   = 6'h08;
   localparam logic [5:0] OFF_PD_PIN   = 6'h09;
   localparam logic [5:0] OFF_PD_DIR   = 6'h0A;
   localparam logic [5:0] OFF_PD_OUT   = 6'h0B;
   localparam logic [5:0] OFF_T0_FLAG  = 6'h15;
   localparam logic [5:0] OFF_T2_FLAG  = 6'h17;
   localparam logic [5:0] OFF_PCH_FLAG = 6'h1B;
   localparam logic [5:0] OFF_EXT_FLAG = 6'h1C;
   localparam logic [5:0] OFF_EXT_MASK = 6'h1D;
   localparam logic [5:0] OFF_SCR0     = 6'h1E;
   localparam logic [5:0] OFF_NVM_CTL  = 6'h1F;
   localparam logic [5:0] OFF_NVM_DATA = 6'h20;
   localparam logic [5:0] OFF_NVM_ADL  = 6'h21;
   localparam logic [5:0] OFF_NVM_ADH  = 6'h22;
   localparam logic [5:0] OFF_PRESC    = 6'h23;
   localparam logic [5:0] OFF_T0_CTLA  = 6'h24;
   localparam logic [5:0] OFF_T0_CTLB  = 6'h25;
   localparam logic [5:0] OFF_T0_CNT   = 6'h26;
   localparam logic [5:0] OFF_T0_CMPA  = 6'h27;
   localparam logic [5:0] OFF_T0_CMPB  = 6'h28;
   localparam logic [5:0] OFF_SCR1     = 6'h2A;
   localparam logic [5:0] OFF_SCR2     = 6'h2B;
   localparam logic [5:0] OFF_SPI_CTL  = 6'h2C;
   localparam logic [5:0] OFF_SPI_STAT = 6'h2D;
   localparam logic [5:0] OFF_SPI_DATA = 6'h2E;
   localparam logic [5:0] OFF_CMP_CS   = 6'h30;
   localparam logic [5:0] OFF_SLEEP    = 6'h33;

   // ****************************************
   // implemented-bit masks
   // ****************************************
   localparam logic [7:0] MASK_FULL   = 8'hFF;
   localparam logic [7:0] MASK_NONE   = 8'h00;
   localparam logic [7:0] MASK_PORT_C = 8'h7F; // port c has seven lines
   localparam logic [7:0] MASK_TFLAG  = 8'h07; // timer and pin-change flags
   localparam logic [7:0] MASK_EXT    = 8'h03; // two external lines
   localparam logic [7:0] MASK_NVM    = 8'h3F;
   localparam logic [7:0] MASK_PRESC  = 8'h83;
   localparam logic [7:0] MASK_CTLA   = 8'hF3;
   localparam logic [7:0] MASK_CTLB   = 8'hCF;
   localparam logic [7:0] MASK_SPIST  = 8'h01;
   localparam logic [7:0] MASK_CMP    = 8'hDF;
   localparam logic [7:0] MASK_SLEEP  = 8'h0F;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [3:0] {
      op_none, op_in, op_out, op_set_io_bit, op_clear_io_bit,
      op_skip_if_set, op_skip_if_clear, op_load, op_store
   } iosd_op_e;

   typedef struct packed {
      iosd_op_e   op;      // access kind
      logic [7:0] addr;    // i/o address or data-space address
      logic [2:0] bit_idx; // bit for single-bit operations
      logic [7:0] wdata;   // write data
   } iosd_req_s;

   typedef struct packed {
      logic       valid;   // one-cycle reply strobe
      logic       err;     // access refused
      logic       skip;    // bit test matched
      logic [7:0] rdata;
   } iosd_resp_s;

   typedef struct packed {
      logic       valid;   // one-cycle strobe to extended region
      logic       write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } iosd_ext_s;

   typedef struct packed {
      logic [7:0] timer0;
      logic [7:0] timer2;
      logic [7:0] pin_chg;
      logic [7:0] ext_int;
   } iosd_flags_s;

   typedef struct packed {
      logic [7:0] b;
      logic [7:0] c;
      logic [7:0] d;
   } iosd_pins_s;

   typedef logic [IO_SPAN-1:0][7:0] iosd_image_t;

endpackage

// ==== hdl/iosd_decoder.sv ====
// module: i/o space decoder with bit access and write-one-clear flags
`timescale 1ns/1ns

// Notes on behaviour
// - bit set/clear on addresses 0x00-0x1F
// - bit test with skip on 0x00-0x1F
// - bit operation writes only addressed bit
// - status flags cleared by writing one
// - short in/out decode six-bit address
// - data space sees i/o at +0x20
// - extended region only by load/store
module iosd_decoder (
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   input  wire iosd_pkg::iosd_req_s   req,
   output iosd_pkg::iosd_resp_s       resp,
   input  wire iosd_pkg::iosd_pins_s  pins,
   input  wire iosd_pkg::iosd_flags_s flag_set,
   output iosd_pkg::iosd_ext_s        ext,
   input  wire logic [7:0]           ext_rdata,
   output iosd_pkg::iosd_image_t      io_regs
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      iosd_pkg::iosd_image_t io;   // stored register image
      iosd_pkg::iosd_resp_s  resp; // registered reply
      iosd_pkg::iosd_ext_s   ext;  // registered extended strobe
   } iosd_state_s;

   iosd_state_s s;       // current state
   iosd_state_s next_s;  // next state

   // ****************************************
   // decode functions
   // ****************************************
   // software-writable bits per location; zero means read-only/reserved
   function automatic logic [7:0] wmask(input logic [5:0] i);
      logic [7:0] m;
      m = iosd_pkg::MASK_NONE;
      if (i == iosd_pkg::OFF_PB_DIR || i == iosd_pkg::OFF_PB_OUT ||
          i == iosd_pkg::OFF_PD_DIR || i == iosd_pkg::OFF_PD_OUT)
         m = iosd_pkg::MASK_FULL;
      else if (i == iosd_pkg::OFF_PC_DIR || i == iosd_pkg::OFF_PC_OUT)
         m = iosd_pkg::MASK_PORT_C;
      else if (i == iosd_pkg::OFF_EXT_MASK)
         m = iosd_pkg::MASK_EXT;
      else if (i == iosd_pkg::OFF_SCR0 || i == iosd_pkg::OFF_SCR1 ||
               i == iosd_pkg::OFF_SCR2 || i == iosd_pkg::OFF_NVM_DATA ||
               i == iosd_pkg::OFF_NVM_ADL || i == iosd_pkg::OFF_NVM_ADH)
         m = iosd_pkg::MASK_FULL;
      else if (i == iosd_pkg::OFF_T0_CNT || i == iosd_pkg::OFF_T0_CMPA ||
               i == iosd_pkg::OFF_T0_CMPB || i == iosd_pkg::OFF_SPI_CTL ||
               i == iosd_pkg::OFF_SPI_DATA)
         m = iosd_pkg::MASK_FULL;
      else if (i == iosd_pkg::OFF_NVM_CTL)
         m = iosd_pkg::MASK_NVM;
      else if (i == iosd_pkg::OFF_PRESC)
         m = iosd_pkg::MASK_PRESC;
      else if (i == iosd_pkg::OFF_T0_CTLA)
         m = iosd_pkg::MASK_CTLA;
      else if (i == iosd_pkg::OFF_T0_CTLB)
         m = iosd_pkg::MASK_CTLB;
      else if (i == iosd_pkg::OFF_SPI_STAT)
         m = iosd_pkg::MASK_SPIST;
      else if (i == iosd_pkg::OFF_CMP_CS)
         m = iosd_pkg::MASK_CMP;
      else if (i == iosd_pkg::OFF_SLEEP)
         m = iosd_pkg::MASK_SLEEP;
      return m;
   endfunction

   // write-one-to-clear flag bits per location
   function automatic logic [7:0] cmask(input logic [5:0] i);
      logic [7:0] m;
      m = iosd_pkg::MASK_NONE;
      if (i == iosd_pkg::OFF_T0_FLAG || i == iosd_pkg::OFF_T2_FLAG ||
          i == iosd_pkg::OFF_PCH_FLAG)
         m = iosd_pkg::MASK_TFLAG;
      else if (i == iosd_pkg::OFF_EXT_FLAG)
         m = iosd_pkg::MASK_EXT;
      return m;
   endfunction

   // read value; pin registers show the live port inputs
   function automatic logic [7:0] read_io(input logic [5:0] i,
                                          input iosd_state_s cur,
                                          input iosd_pkg::iosd_pins_s p);
      logic [7:0] v;
      v = iosd_pkg::MASK_NONE;
      if (i == iosd_pkg::OFF_PB_PIN)
         v = p.b;
      else if (i == iosd_pkg::OFF_PC_PIN)
         v = p.c & iosd_pkg::MASK_PORT_C;
      else if (i == iosd_pkg::OFF_PD_PIN)
         v = p.d;
      else
         v = cur.io[i] & (wmask(i) | cmask(i));
      return v;
   endfunction

   // ****************************************
   // request decode
   // ****************************************
   logic       io_hit;   // request lands in the 64-location image
   logic       ext_hit;  // request lands in extended region
   logic       refused;  // request outside what its kind may reach
   logic       do_write; // request writes the image
   logic [5:0] idx;      // image index
   logic [7:0] lanes;    // bits touched by the write
   logic [7:0] rd;       // read value at idx

   // sort requests by kind and address
   always_comb begin
      io_hit   = 1'b0;
      ext_hit  = 1'b0;
      refused  = 1'b0;
      do_write = 1'b0;
      idx      = req.addr[5:0];
      lanes    = iosd_pkg::MASK_FULL;
      case (req.op)
         iosd_pkg::op_in, iosd_pkg::op_out: begin
            io_hit   = 1'b1;
            do_write = (req.op == iosd_pkg::op_out);
         end
         // bit operations only in the low 32 locations
         iosd_pkg::op_set_io_bit, iosd_pkg::op_clear_io_bit,
         iosd_pkg::op_skip_if_set, iosd_pkg::op_skip_if_clear: begin
            if (req.addr[7:5] == iosd_pkg::BIT_SPAN_TOP) begin
               io_hit   = 1'b1;
               do_write = (req.op == iosd_pkg::op_set_io_bit) ||
                          (req.op == iosd_pkg::op_clear_io_bit);
               lanes    = 8'h01 << req.bit_idx;
            end else begin
               refused = 1'b1;
            end
         end
         // data space sees the image at +0x20
         iosd_pkg::op_load, iosd_pkg::op_store: begin
            if (req.addr >= iosd_pkg::DS_EXT_BASE) begin
               ext_hit = 1'b1;
            end else if (req.addr >= iosd_pkg::DS_IO_BASE) begin
               io_hit   = 1'b1;
               idx      = 6'(req.addr - iosd_pkg::DS_IO_BASE);
               do_write = (req.op == iosd_pkg::op_store);
            end else begin
               // core register file below 0x20 is not ours
               refused = 1'b1;
            end
         end
         default: begin
            io_hit = 1'b0;
         end
      endcase
      rd = read_io(idx, s, pins);
   end

   // ****************************************
   // next state
   // ****************************************
   // the flag merge runs after the write so a same-cycle event wins
   always_comb begin
      logic [7:0] wd;
      wd = (req.op == iosd_pkg::op_set_io_bit) ? iosd_pkg::MASK_FULL :
           (req.op == iosd_pkg::op_clear_io_bit) ? iosd_pkg::MASK_NONE :
           req.wdata;
      next_s           = s;
      next_s.resp      = '0;
      next_s.ext       = '0;
      next_s.resp.valid = (req.op != iosd_pkg::op_none);
      next_s.resp.err   = refused;
      if (io_hit && do_write) begin
         // flags clear on one, plain bits take data
         // masks keep reserved bits and addresses inert
         next_s.io[idx] = (s.io[idx] & ~(wmask(idx) & lanes))
                        | (wd & wmask(idx) & lanes);
         next_s.io[idx] = next_s.io[idx] & ~(wd & cmask(idx) & lanes);
      end else if (io_hit) begin
         next_s.resp.rdata = rd;
         // bit test drives the skip answer
         if (req.op == iosd_pkg::op_skip_if_set)
            next_s.resp.skip = rd[req.bit_idx];
         else if (req.op == iosd_pkg::op_skip_if_clear)
            next_s.resp.skip = ~rd[req.bit_idx];
      end else if (ext_hit) begin
         next_s.ext.valid  = 1'b1;
         next_s.ext.write  = (req.op == iosd_pkg::op_store);
         next_s.ext.addr   = req.addr;
         next_s.ext.wdata  = req.wdata;
         next_s.resp.rdata = (req.op == iosd_pkg::op_load) ? ext_rdata
                                                            : 8'h00;
      end
      // hardware set beats a software clear
      next_s.io[iosd_pkg::OFF_T0_FLAG] |= flag_set.timer0 &
                                          iosd_pkg::MASK_TFLAG;
      next_s.io[iosd_pkg::OFF_T2_FLAG] |= flag_set.timer2 &
                                          iosd_pkg::MASK_TFLAG;
      next_s.io[iosd_pkg::OFF_PCH_FLAG] |= flag_set.pin_chg &
                                           iosd_pkg::MASK_TFLAG;
      next_s.io[iosd_pkg::OFF_EXT_FLAG] |= flag_set.ext_int &
                                           iosd_pkg::MASK_EXT;
   end

   // ****************************************
   // state register and outputs
   // ****************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign resp    = s.resp;
   assign ext     = s.ext;
   assign io_regs = s.io;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   bit_set_a: assert property (
      req.op == iosd_pkg::op_set_io_bit && req.addr == 8'h1E
      |=> s.io[iosd_pkg::OFF_SCR0][$past(req.bit_idx)])
      else $error("bit set did not land");

   bit_only_a: assert property (
      req.op == iosd_pkg::op_clear_io_bit && req.addr == 8'h1E
      |=> (s.io[iosd_pkg::OFF_SCR0] | (8'h01 << $past(req.bit_idx))) ==
          ($past(s.io[iosd_pkg::OFF_SCR0]) | (8'h01 << $past(req.bit_idx))))
      else $error("bit clear touched other bits");

   skip_test_a: assert property (
      req.op == iosd_pkg::op_skip_if_set && req.addr == 8'h1E
      |=> resp.valid && !resp.err && resp.skip ==
          $past(s.io[iosd_pkg::OFF_SCR0][req.bit_idx]))
      else $error("skip answer wrong");

   flag_clear_a: assert property (
      req.op == iosd_pkg::op_out && req.addr == 8'h15 &&
      flag_set.timer0 == 8'h00
      |=> s.io[iosd_pkg::OFF_T0_FLAG] ==
          ($past(s.io[iosd_pkg::OFF_T0_FLAG]) & ~$past(req.wdata)))
      else $error("flag write-one clear wrong");

   set_wins_a: assert property (
      flag_set.ext_int[0] |=> s.io[iosd_pkg::OFF_EXT_FLAG][0])
      else $error("flag event lost");

   short_io_a: assert property (
      req.op == iosd_pkg::op_in |=> resp.valid && !resp.err && !ext.valid)
      else $error("short read not served");

   ds_map_a: assert property (
      req.op == iosd_pkg::op_store && req.addr == 8'h4A
      |=> s.io[iosd_pkg::OFF_SCR1] == $past(req.wdata))
      else $error("data-space store misplaced");

   ext_only_a: assert property (
      (req.op == iosd_pkg::op_load || req.op == iosd_pkg::op_store) &&
      req.addr >= 8'h60 |=> ext.valid && ext.addr == $past(req.addr))
      else $error("extended access not forwarded");

   no_bit_hi_a: assert property (
      req.op == iosd_pkg::op_set_io_bit && req.addr >= 8'h20
      |=> resp.valid && resp.err)
      else $error("high bit op not refused");

   reserved_a: assert property (
      req.op == iosd_pkg::op_in && req.addr == 8'h0C
      |=> resp.rdata == 8'h00)
      else $error("reserved read not zero");

   skip_hit_c: cover property (
      req.op == iosd_pkg::op_skip_if_clear ##1 resp.skip);
   ext_store_c: cover property (ext.valid && ext.write);
   race_c: cover property (
      req.op == iosd_pkg::op_set_io_bit && req.addr == 8'h15 &&
      flag_set.timer0 != 8'h00);

endmodule

// ==== verif/iosd_core_model.sv ====
// partner model: core issuing i/o and data-space accesses
`timescale 1ns/1ns

module iosd_core_model (
   input  wire logic                 clk,
   output iosd_pkg::iosd_req_s       req,
   input  wire iosd_pkg::iosd_resp_s resp,
   input  wire iosd_pkg::iosd_ext_s  ext
);

   // ********************
   // reserved map
   // ********************
   // reserved short i/o locations
   function automatic logic is_rsv(input logic [5:0] a);
      return (a <= 6'h02) || (a >= 6'h0C && a <= 6'h14) || (a == 6'h16) ||
             (a >= 6'h18 && a <= 6'h1A) || (a == 6'h29) || (a == 6'h2F) ||
             (a == 6'h31) || (a == 6'h32);
   endfunction

   // core stays idle until asked
   initial begin
      req = '0;
   end

   // one access: drive after an edge, hold one edge, take reply
   task automatic access(input iosd_pkg::iosd_op_e op,
                         input logic [7:0] a, input logic [2:0] b,
                         input logic [7:0] d, input logic rogue,
                         output iosd_pkg::iosd_resp_s r,
                         output iosd_pkg::iosd_ext_s e);
      logic       wr;
      logic [7:0] dd;
      wr = (op == iosd_pkg::op_out);
      dd = d;
      r = '0;
      e = '0;
      if (!rogue && wr && (a[5:0] == iosd_pkg::OFF_PC_OUT)) begin
         dd[7] = 1'b0;
      end
      if (!rogue && wr && is_rsv(a[5:0])) begin
         return;
      end
      @(posedge clk);
      #1;
      req = '{op: op, addr: a, bit_idx: b, wdata: dd};
      @(posedge clk);
      #1;
      r = resp;
      e = ext;
      req = '0;
   endtask

endmodule

// ==== verif/tb.sv ====
// testbench: scenario tasks around the i/o space decoder
`timescale 1ns/1ns

module tb;
   logic                  clk;        // core clock, 8 ns
   logic                  reset_n;    // async reset, active low
   iosd_pkg::iosd_req_s   req;        // request from core model
   iosd_pkg::iosd_resp_s  resp;       // registered reply
   iosd_pkg::iosd_pins_s  pins;       // live pin levels
   iosd_pkg::iosd_flags_s flag_set;   // peripheral flag events
   iosd_pkg::iosd_ext_s   ext;        // extended region strobe
   logic [7:0]            ext_rdata;  // extended region read data
   iosd_pkg::iosd_image_t io_regs;    // stored register image
   iosd_pkg::iosd_resp_s  r;          // last reply taken
   iosd_pkg::iosd_ext_s   e;          // last extended strobe taken
   int                    mismatches; // failed compares
   int                    tests_run;  // compares made

   iosd_decoder iosd_decoder_inst (
      .clk(clk), .reset_n(reset_n), .req(req), .resp(resp), .pins(pins),
      .flag_set(flag_set), .ext(ext), .ext_rdata(ext_rdata),
      .io_regs(io_regs));

   iosd_core_model iosd_core_model_inst (
      .clk(clk), .req(req), .resp(resp), .ext(ext));

   // free-running clock
   always #4 clk = ~clk;

   // ********************
   // helpers
   // ********************
   // compare and count
   task automatic check(input string n, input logic [7:0] got,
                        input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, exp, got);
      end
   endtask

   // one access; every taken request must be answered
   task automatic acc(input iosd_pkg::iosd_op_e op, input logic [7:0] a,
                      input logic [2:0] b = 3'h0, input logic [7:0] d = 8'h00,
                      input logic rogue = 1'b0);
      iosd_core_model_inst.access(op, a, b, d, rogue, r, e);
      check("valid", {7'h00, r.valid}, 8'h01);
   endtask

   // ********************
   // scenarios
   // ********************
   // bit set/clear on low space, refusal above it
   task automatic t_bit;
      acc(iosd_pkg::op_out, 8'h1E, 3'h0, 8'hA5);
      acc(iosd_pkg::op_set_io_bit, 8'h1E, 3'h1);
      check("set_b1", io_regs[30], 8'hA7);
      acc(iosd_pkg::op_clear_io_bit, 8'h1E, 3'h7);
      check("clr_b7", io_regs[30], 8'h27);
      acc(iosd_pkg::op_set_io_bit, 8'h20, 3'h0);
      check("set_hi_err", {7'h00, r.err}, 8'h01);
      check("set_hi_keep", io_regs[32], 8'h00);
      $display("test bit ops done");
   endtask

   // bit test with skip, both senses; refused above low space
   task automatic t_skip;
      acc(iosd_pkg::op_skip_if_set, 8'h1E, 3'h0);
      check("sis_b0", {7'h00, r.skip}, 8'h01);
      check("sis_data", r.rdata, 8'h27);
      acc(iosd_pkg::op_skip_if_clear, 8'h1E, 3'h0);
      check("sic_b0", {7'h00, r.skip}, 8'h00);
      acc(iosd_pkg::op_skip_if_clear, 8'h1E, 3'h3);
      check("sic_b3", {7'h00, r.skip}, 8'h01);
      acc(iosd_pkg::op_skip_if_set, 8'h1E, 3'h3);
      check("sis_b3", {7'h00, r.skip}, 8'h00);
      acc(iosd_pkg::op_skip_if_set, 8'h25, 3'h0);
      check("skip_hi_err", {7'h00, r.err}, 8'h01);
      // walk every bit index so a swapped index shows
      acc(iosd_pkg::op_out, 8'h1E, 3'h0, 8'h00);
      for (int i = 0; i < 8; i++) begin
         acc(iosd_pkg::op_set_io_bit, 8'h1E, i[2:0]);
         check("set_walk", io_regs[30], 8'((2 << i) - 1));
      end
      $display("test skip done");
   endtask

   // write-one-clear flags, bit ops leave other flags alone
   task automatic t_w1c;
      @(posedge clk);
      #1;
      flag_set.timer0 = 8'h07;
      flag_set.ext_int = 8'hFF;
      flag_set.timer2 = 8'hFF;
      flag_set.pin_chg = 8'h05;
      @(posedge clk);
      #1;
      flag_set = '0;
      acc(iosd_pkg::op_in, 8'h1C);
      check("ext_flags", r.rdata, 8'h03);
      check("t2_flags", io_regs[23], 8'h07);
      check("pch_flags", io_regs[27], 8'h05);
      acc(iosd_pkg::op_out, 8'h15, 3'h0, 8'h00);
      check("w0_keep", io_regs[21], 8'h07);
      acc(iosd_pkg::op_out, 8'h15, 3'h0, 8'h01);
      check("w1_clear", io_regs[21], 8'h06);
      acc(iosd_pkg::op_set_io_bit, 8'h15, 3'h2);
      check("sbit_flag", io_regs[21], 8'h02);
      acc(iosd_pkg::op_clear_io_bit, 8'h15, 3'h1);
      check("cbit_flag", io_regs[21], 8'h02);
      // event and software clear on one edge: the event must win
      flag_set.timer0 = 8'h01;
      acc(iosd_pkg::op_set_io_bit, 8'h15, 3'h0);
      flag_set = '0;
      check("race_set", io_regs[21], 8'h03);
      $display("test flags done");
   endtask

   // short decode, data-space offset, extended region
   task automatic t_map;
      acc(iosd_pkg::op_out, 8'hEA, 3'h0, 8'h3C);
      check("out_6bit", io_regs[42], 8'h3C);
      acc(iosd_pkg::op_load, 8'h4A);
      check("load_off", r.rdata, 8'h3C);
      acc(iosd_pkg::op_store, 8'h4B, 3'h0, 8'h5A);
      acc(iosd_pkg::op_in, 8'h2B);
      check("store_off", r.rdata, 8'h5A);
      ext_rdata = 8'hC3;
      acc(iosd_pkg::op_load, 8'h80);
      check("ext_rd", r.rdata, 8'hC3);
      check("ext_rd_v", {6'h00, e.valid, e.write}, 8'h02);
      check("ext_rd_a", e.addr, 8'h80);
      acc(iosd_pkg::op_store, 8'hFF, 3'h0, 8'h99);
      check("ext_wr_v", {6'h00, e.valid, e.write}, 8'h03);
      check("ext_wr", e.wdata ^ e.addr, 8'h66);
      acc(iosd_pkg::op_load, 8'h10);
      check("load_lo_err", {7'h00, r.err}, 8'h01);
      $display("test map done");
   endtask

   // reserved places and pin locations
   task automatic t_rsv;
      acc(iosd_pkg::op_out, 8'h0C, 3'h0, 8'hFF, 1'b1);
      acc(iosd_pkg::op_in, 8'h0C);
      check("rsv_rd", r.rdata, 8'h00);
      check("rsv_side", io_regs[11], 8'h00);
      acc(iosd_pkg::op_in, 8'h06);
      check("port_c_pin_input_mask", r.rdata, 8'h7F);
      acc(iosd_pkg::op_out, 8'h03, 3'h0, 8'h00, 1'b1);
      acc(iosd_pkg::op_in, 8'h03);
      check("port_b_pin_input_live", r.rdata, 8'h5A);
      acc(iosd_pkg::op_in, 8'h09);
      check("port_d_pin_input_live", r.rdata, 8'h81);
      acc(iosd_pkg::op_out, 8'h08, 3'h0, 8'hFF, 1'b1);
      check("port_c_output_rsv", io_regs[8], 8'h7F);
      $display("test reserved done");
   endtask

   // verdict and end of run
   task automatic end_sim;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      pins = '{b: 8'h5A, c: 8'hFF, d: 8'h81};
      flag_set = '0;
      ext_rdata = 8'h00;
      mismatches = 0;
      tests_run = 0;
      repeat (10) @(posedge clk);
      #1;
      reset_n = 1'b1;
      t_bit();
      t_skip();
      t_w1c();
      t_map();
      t_rsv();
      end_sim();
   end

   // watchdog: run needs about a hundred cycles, limit is 3000
   initial begin
      #(3000 * 8);
      mismatches++;
      $display("watchdog expired");
      end_sim();
   end

endmodule
